/* pkg/hcs_consts.svh */
`ifndef HCS_CONSTS_SVH
`define HCS_CONSTS_SVH
// Functional notes
// - Codes 128..169 are massage-only functions
// - Motor codes 137..140, toggles 166 and 167
// - Intensity codes 141..144, both channels 168/169
// - Code 255 is wakeup, never starts motors
// - Second handset answers id 38 with code
// - Byte 2 bits 4-5 select code set
// - Id 39/40 answer is one sequence byte
// - Reply follows last valid value in sequence
// - Unknown position sends the first entry
// - Monitor valid safety frames, reply next value
// - Track both 39 and 40, answer own
// - No safety answer unless key pressed
// - Master enables motors only on correct answers
// - Three consecutive valid values after unknown position
// - Master alone schedules frames, idle or active
// - Desk idle 37,39,0,10,36; active 37,39,0
// - More references extend idle schedule
// - Dual drive uses 35; idle 17,35,36
// - Prefer 37 over 35 for handset input

// ==================== Frame identifiers
`define HCS_ID_CMD1 6'h25
`define HCS_ID_CMD2 6'h26
`define HCS_ID_SAFE1 6'h27
`define HCS_ID_SAFE2 6'h28
`define HCS_ID_POS 6'h00
`define HCS_ID_REF 6'h0a
`define HCS_ID_STAT 6'h24

// ==================== Function codes
`define HCS_FC_MASSAGE_LO 8'h80
`define HCS_FC_AUX_LO 8'h92
`define HCS_FC_AUX_HI 8'ha5
`define HCS_FC_MOTOR1_ON 8'h89
`define HCS_FC_MOTOR2_OFF 8'h8c
`define HCS_FC_INT1_UP 8'h8d
`define HCS_FC_INT2_DN 8'h90
`define HCS_FC_MOTOR1_TGL 8'ha6
`define HCS_FC_MOTOR2_TGL 8'ha7
`define HCS_FC_INT_BOTH_UP 8'ha8
`define HCS_FC_INT_BOTH_DN 8'ha9
`define HCS_FC_WAKEUP 8'hff

// ==================== Code set field in data byte 2
`define HCS_SET_LSB 4
`define HCS_SET_UNDEF 2'h3

// ==================== Safety key sequence
`define HCS_SEQ_LEN 4'h9
`define HCS_SEQ0 8'h3f
`define HCS_SEQ1 8'hdf
`define HCS_SEQ2 8'hcf
`define HCS_SEQ3 8'hd7
`define HCS_SEQ4 8'hc3
`define HCS_SEQ5 8'hdd
`define HCS_SEQ6 8'hcc
`define HCS_SEQ7 8'h55
`define HCS_SEQ8 8'h80
`define HCS_VALID_RUN 2'h3

// ==================== Timing counts in clk_i cycles
`define HCS_GAP_CYC 16
`define HCS_RESP_WAIT_CYC 4
`endif

/* pkg/hcs_pkg.sv */
`include "hcs_consts.svh"
package hcs_pkg;

    typedef enum logic [2:0] {
        CL_BASIC = 3'b000,
        CL_MASSAGE = 3'b001,
        CL_MOTOR = 3'b010,
        CL_INTENS = 3'b011,
        CL_AUX = 3'b100,
        CL_WAKE = 3'b101,
        CL_UNDEF = 3'b110
    } hcs_class_t;

    typedef enum logic [1:0] {
        HS_LISTEN = 2'b00,
        HS_CMD = 2'b01,
        HS_SAFE = 2'b10
    } hcs_hs_state_t;

    typedef enum logic [1:0] {
        MS_GAP = 2'b00,
        MS_WAIT = 2'b01,
        MS_DONE = 2'b10
    } hcs_ms_state_t;

    function automatic hcs_class_t hcs_classify(input logic [7:0] code);
        hcs_class_t c;
        c = CL_UNDEF;
        if (code < `HCS_FC_MASSAGE_LO) begin
            c = CL_BASIC;
        end else if (code == `HCS_FC_WAKEUP) begin
            c = CL_WAKE;
        end else if (code > `HCS_FC_INT_BOTH_DN) begin
            c = CL_UNDEF;
        end else if ((code >= `HCS_FC_MOTOR1_ON && code <= `HCS_FC_MOTOR2_OFF) ||
                     code == `HCS_FC_MOTOR1_TGL || code == `HCS_FC_MOTOR2_TGL) begin
            c = CL_MOTOR;
        end else if ((code >= `HCS_FC_INT1_UP && code <= `HCS_FC_INT2_DN) ||
                     code == `HCS_FC_INT_BOTH_UP || code == `HCS_FC_INT_BOTH_DN) begin
            c = CL_INTENS;
        end else if (code >= `HCS_FC_AUX_LO && code <= `HCS_FC_AUX_HI) begin
            c = CL_AUX;
        end else begin
            c = CL_MASSAGE;
        end
        return c;
    endfunction : hcs_classify

    function automatic logic [7:0] hcs_seq_val(input logic [3:0] idx);
        unique case (idx)
            4'h0: return `HCS_SEQ0;
            4'h1: return `HCS_SEQ1;
            4'h2: return `HCS_SEQ2;
            4'h3: return `HCS_SEQ3;
            4'h4: return `HCS_SEQ4;
            4'h5: return `HCS_SEQ5;
            4'h6: return `HCS_SEQ6;
            4'h7: return `HCS_SEQ7;
            4'h8: return `HCS_SEQ8;
            default: return `HCS_SEQ0;
        endcase
    endfunction : hcs_seq_val

    // Returns {hit, index}
    function automatic logic [4:0] hcs_seq_find(input logic [7:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 9; i++) begin
            if (hcs_seq_val(4'(i)) == v) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction : hcs_seq_find

endpackage : hcs_pkg

/* pkg/hcs_link_if.sv */
// Frame-level view of the shared bus: header, one response, then a broadcast
// of what every node on the wire received.
interface hcs_link_if;
    logic hdr_valid;
    logic [5:0] hdr_id;
    logic rsp_valid;
    logic rsp_len2;
    logic [7:0] rsp_b0;
    logic [7:0] rsp_b1;
    logic obs_valid;
    logic obs_ok;
    logic [5:0] obs_id;
    logic [7:0] obs_b0;

    modport master (
        output hdr_valid, hdr_id, obs_valid, obs_ok, obs_id, obs_b0,
        input rsp_valid, rsp_len2, rsp_b0, rsp_b1
    );

    modport handset (
        input hdr_valid, hdr_id, obs_valid, obs_ok, obs_id, obs_b0,
        output rsp_valid, rsp_len2, rsp_b0, rsp_b1
    );
endinterface : hcs_link_if

/* design/hcs_seq_tracker.sv */
`include "hcs_consts.svh"
module hcs_seq_tracker (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic obs_valid_i,
    input wire logic [7:0] obs_value_i,
    output logic known_o,
    output logic [7:0] next_value_o,
    output logic match_o
);
    logic [3:0] idx_r;
    logic known_r;
    logic [4:0] found;
    logic [3:0] exp_idx;

    assign found = hcs_pkg::hcs_seq_find(obs_value_i);

    // ==================== Expected next position
    always_comb begin
        if (!known_r) begin
            exp_idx = 4'h0;
        end else if (idx_r == `HCS_SEQ_LEN - 4'h1) begin
            exp_idx = 4'h0;
        end else begin
            exp_idx = idx_r + 4'h1;
        end
    end

    assign next_value_o = hcs_pkg::hcs_seq_val(exp_idx);
    assign match_o = obs_valid_i && found[4] && found[3:0] == exp_idx;
    assign known_o = known_r;

    // ==================== Position update
    // Any sequence member resyncs; a foreign byte drops to unknown.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            idx_r <= 4'h0;
            known_r <= 1'b0;
        end else if (obs_valid_i) begin
            idx_r <= found[3:0];
            known_r <= found[4];
        end
    end
endmodule : hcs_seq_tracker

/* design/hcs_handset.sv */
`include "hcs_consts.svh"
module hcs_handset #(
    parameter bit SECOND = 1'b0
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    hcs_link_if.handset lnk,
    input wire logic key_pressed_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [1:0] cmd_set_i,
    output logic seq_known_o,
    output logic [7:0] next_seq_o,
    output hcs_pkg::hcs_class_t cmd_class_o,
    output logic cmd_sent_o,
    output logic safety_sent_o
);

    // ==================== Identity on the bus
    // Second handset uses the second command and safety frames.
    localparam logic [5:0] CMD_ID = SECOND ? `HCS_ID_CMD2 : `HCS_ID_CMD1;
    localparam logic [5:0] SAFE_ID = SECOND ? `HCS_ID_SAFE2 : `HCS_ID_SAFE1;

    hcs_pkg::hcs_hs_state_t state_r;
    hcs_pkg::hcs_hs_state_t state_nxt;

    logic hdr_cmd;
    logic hdr_safe;
    logic obs_safe;
    logic trk_known;
    logic [7:0] trk_next;
    logic [7:0] code_sel;
    logic [1:0] set_sel;
    hcs_pkg::hcs_class_t class_sel;

    logic [7:0] rsp_b0_r;
    logic [7:0] rsp_b1_r;
    logic rsp_len2_r;
    hcs_pkg::hcs_class_t cmd_class_r;
    logic cmd_sent_r;
    logic safety_sent_r;

    // ==================== Header decode
    assign hdr_cmd = lnk.hdr_valid && lnk.hdr_id == CMD_ID;

    // Silent on the safety frame while no key is held.
    assign hdr_safe = lnk.hdr_valid && lnk.hdr_id == SAFE_ID && key_pressed_i;

    // Both safety frames feed the tracker, whoever answered them.
    assign obs_safe = lnk.obs_valid && lnk.obs_ok &&
                      (lnk.obs_id == `HCS_ID_SAFE1 || lnk.obs_id == `HCS_ID_SAFE2);

    // ==================== Sequence position
    hcs_seq_tracker u_trk (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .obs_valid_i(obs_safe),
        .obs_value_i(lnk.obs_b0),
        .known_o(trk_known),
        .next_value_o(trk_next),
        .match_o()
    );

    // ==================== Command byte selection
    assign class_sel = hcs_pkg::hcs_classify(cmd_code_i);

    // Released key or an unassigned code reads as wakeup, so the box
    // never starts a motor on stale or garbage input.
    always_comb begin
        if (!key_pressed_i || class_sel == hcs_pkg::CL_UNDEF) begin
            code_sel = `HCS_FC_WAKEUP;
        end else begin
            code_sel = cmd_code_i;
        end
    end

    // Undefined code set falls back to default.
    always_comb begin
        if (cmd_set_i == `HCS_SET_UNDEF) begin
            set_sel = 2'h0;
        end else begin
            set_sel = cmd_set_i;
        end
    end

    // ==================== Answer state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            hcs_pkg::HS_LISTEN: begin
                if (hdr_cmd) begin
                    state_nxt = hcs_pkg::HS_CMD;
                end else if (hdr_safe) begin
                    state_nxt = hcs_pkg::HS_SAFE;
                end
            end
            hcs_pkg::HS_CMD: begin
                state_nxt = hcs_pkg::HS_LISTEN;
            end
            hcs_pkg::HS_SAFE: begin
                state_nxt = hcs_pkg::HS_LISTEN;
            end
            default: begin
                state_nxt = hcs_pkg::HS_LISTEN;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r <= hcs_pkg::HS_LISTEN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ==================== Response data
    // Captured at the header so the bytes stay still while answered.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rsp_b0_r <= 8'h00;
            rsp_b1_r <= 8'h00;
            rsp_len2_r <= 1'b0;
        end else if (state_r == hcs_pkg::HS_LISTEN && hdr_cmd) begin
            rsp_b0_r <= code_sel;
            rsp_b1_r <= {2'h0, set_sel, 4'h0} ;
            rsp_len2_r <= 1'b1;
        end else if (state_r == hcs_pkg::HS_LISTEN && hdr_safe) begin
            rsp_b0_r <= trk_next;
            rsp_b1_r <= 8'h00;
            rsp_len2_r <= 1'b0;
        end
    end

    assign lnk.rsp_valid = state_r != hcs_pkg::HS_LISTEN;
    assign lnk.rsp_b0 = rsp_b0_r;
    assign lnk.rsp_b1 = rsp_b1_r;
    assign lnk.rsp_len2 = rsp_len2_r;

    // ==================== User status
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmd_class_r <= hcs_pkg::CL_WAKE;
        end else if (state_r == hcs_pkg::HS_LISTEN && hdr_cmd) begin
            cmd_class_r <= hcs_pkg::hcs_classify(code_sel);
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmd_sent_r <= 1'b0;
            safety_sent_r <= 1'b0;
        end else begin
            cmd_sent_r <= state_r == hcs_pkg::HS_LISTEN && hdr_cmd;
            safety_sent_r <= state_r == hcs_pkg::HS_LISTEN && !hdr_cmd && hdr_safe;
        end
    end

    assign cmd_class_o = cmd_class_r;
    assign cmd_sent_o = cmd_sent_r;
    assign safety_sent_o = safety_sent_r;
    assign seq_known_o = trk_known;
    assign next_seq_o = trk_next;

endmodule : hcs_handset

/* design/hcs_master.sv */
`include "hcs_consts.svh"
module hcs_master #(
    parameter bit TWO_HS = 1'b0,
    parameter int GAP_CYC = `HCS_GAP_CYC,
    parameter int RESP_WAIT = `HCS_RESP_WAIT_CYC
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    hcs_link_if.master lnk,
    output logic active_o,
    output logic motor_en_o,
    output logic cmd_valid_o,
    output logic [7:0] cmd_code_o,
    output logic [1:0] cmd_set_o,
    output hcs_pkg::hcs_class_t cmd_class_o
);
    hcs_pkg::hcs_ms_state_t state_r;
    logic [15:0] cnt_r;
    logic [2:0] slot_r;
    logic [5:0] id_r;
    logic got_r;
    logic len2_r;
    logic [7:0] b0_r;
    logic [7:0] b1_r;
    logic active_r;
    logic motor_r;
    logic [1:0] run_r;
    logic hdr_valid_r;
    logic obs_valid_r;
    logic cmd_valid_r;
    logic [7:0] cmd_code_r;
    logic [1:0] cmd_set_r;
    hcs_pkg::hcs_class_t cmd_class_r;
    logic is_cmd;
    logic is_safe;
    logic seq_ok;
    logic [1:0] run_nxt;

    // ==================== Schedules
    // Desk system with one reference; the second handset frames are optional.
    function automatic logic [5:0] sched_id(input logic act, input logic [2:0] s);
        logic [5:0] r;
        r = `HCS_ID_CMD1;
        unique case (s)
            3'h0: r = `HCS_ID_CMD1;
            3'h1: r = `HCS_ID_SAFE1;
            3'h2: r = `HCS_ID_POS;
            3'h3: r = act ? `HCS_ID_CMD2 : `HCS_ID_REF;
            3'h4: r = act ? `HCS_ID_SAFE2 : `HCS_ID_STAT;
            3'h5: r = `HCS_ID_CMD2;
            3'h6: r = `HCS_ID_SAFE2;
            default: r = `HCS_ID_CMD1;
        endcase
        return r;
    endfunction : sched_id

    function automatic logic [2:0] sched_len(input logic act);
        return act ? (TWO_HS ? 3'h5 : 3'h3) : (TWO_HS ? 3'h7 : 3'h5);
    endfunction : sched_len

    assign is_cmd = id_r == `HCS_ID_CMD1 || id_r == `HCS_ID_CMD2;
    assign is_safe = id_r == `HCS_ID_SAFE1 || id_r == `HCS_ID_SAFE2;

    hcs_seq_tracker u_trk (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .obs_valid_i(state_r == hcs_pkg::MS_DONE && got_r && is_safe),
        .obs_value_i(b0_r),
        .known_o(),
        .next_value_o(),
        .match_o(seq_ok)
    );

    // ==================== Frame sequencer
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r <= hcs_pkg::MS_GAP;
            cnt_r <= 16'(GAP_CYC);
            slot_r <= 3'h0;
            id_r <= 6'h00;
            got_r <= 1'b0;
            len2_r <= 1'b0;
            b0_r <= 8'h00;
            b1_r <= 8'h00;
        end else begin
            unique case (state_r)
                hcs_pkg::MS_GAP: begin
                    if (cnt_r == 16'h0000) begin
                        id_r <= sched_id(active_r, slot_r);
                        got_r <= 1'b0;
                        cnt_r <= 16'(RESP_WAIT);
                        state_r <= hcs_pkg::MS_WAIT;
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                hcs_pkg::MS_WAIT: begin
                    if (lnk.rsp_valid) begin
                        got_r <= 1'b1;
                        len2_r <= lnk.rsp_len2;
                        b0_r <= lnk.rsp_b0;
                        b1_r <= lnk.rsp_b1;
                        state_r <= hcs_pkg::MS_DONE;
                    end else if (cnt_r == 16'h0000) begin
                        state_r <= hcs_pkg::MS_DONE;
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                hcs_pkg::MS_DONE: begin
                    cnt_r <= 16'(GAP_CYC);
                    slot_r <= (slot_r + 3'h1 >= sched_len(active_r)) ? 3'h0 : slot_r + 3'h1;
                    state_r <= hcs_pkg::MS_GAP;
                end
                default: begin
                    state_r <= hcs_pkg::MS_GAP;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hdr_valid_r <= 1'b0;
            obs_valid_r <= 1'b0;
        end else begin
            hdr_valid_r <= state_r == hcs_pkg::MS_GAP && cnt_r == 16'h0000;
            obs_valid_r <= state_r == hcs_pkg::MS_DONE;
        end
    end

    assign lnk.hdr_valid = hdr_valid_r;
    assign lnk.hdr_id = id_r;
    assign lnk.obs_valid = obs_valid_r;
    assign lnk.obs_ok = got_r;
    assign lnk.obs_id = id_r;
    assign lnk.obs_b0 = b0_r;

    // ==================== Command frames and system state
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmd_valid_r <= 1'b0;
            cmd_code_r <= `HCS_FC_WAKEUP;
            cmd_set_r <= 2'h0;
            cmd_class_r <= hcs_pkg::CL_WAKE;
            active_r <= 1'b0;
        end else begin
            cmd_valid_r <= 1'b0;
            if (state_r == hcs_pkg::MS_DONE && is_cmd) begin
                if (got_r && len2_r) begin
                    cmd_valid_r <= 1'b1;
                    cmd_code_r <= b0_r;
                    cmd_set_r <= b1_r[`HCS_SET_LSB +: 2];
                    cmd_class_r <= hcs_pkg::hcs_classify(b0_r);
                    active_r <= b0_r != `HCS_FC_WAKEUP;
                end else begin
                    active_r <= 1'b0;
                end
            end
        end
    end

    // ==================== Motor output gate
    assign run_nxt = (got_r && seq_ok) ? ((run_r == `HCS_VALID_RUN) ? run_r : run_r + 2'h1) : 2'h0;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            run_r <= 2'h0;
            motor_r <= 1'b0;
        end else if (state_r == hcs_pkg::MS_DONE && is_safe) begin
            run_r <= run_nxt;
            // Wakeup never opens the outputs, even with a good sequence.
            motor_r <= run_nxt == `HCS_VALID_RUN && active_r &&
                       cmd_class_r != hcs_pkg::CL_WAKE;
        end else if (!active_r) begin
            motor_r <= 1'b0;
        end
    end

    assign active_o = active_r;
    assign motor_en_o = motor_r;
    assign cmd_valid_o = cmd_valid_r;
    assign cmd_code_o = cmd_code_r;
    assign cmd_set_o = cmd_set_r;
    assign cmd_class_o = cmd_class_r;
endmodule : hcs_master

/* dv/hcs_link_chk.sv */
module hcs_link_chk (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic hdr_valid,
    input wire logic [5:0] hdr_id,
    input wire logic rsp_valid,
    input wire logic rsp_len2,
    input wire logic [7:0] rsp_b0,
    input wire logic [7:0] rsp_b1,
    input wire logic obs_valid,
    input wire logic obs_ok,
    input wire logic [5:0] obs_id,
    input wire logic [7:0] obs_b0
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] SEQ [9] = '{8'h3f, 8'hdf, 8'hcf, 8'hd7, 8'hc3, 8'hdd, 8'hcc, 8'h55, 8'h80};
    logic known_r;
    logic [3:0] idx_r;
    logic [7:0] exp_next;

    // ========================================
    // Shadow of the sequence position seen on the wire
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            known_r <= 1'b0;
            idx_r <= 4'h0;
        end else if (obs_valid && obs_ok && (obs_id == 6'h27 || obs_id == 6'h28)) begin
            known_r <= 1'b0;
            for (int i = 0; i < 9; i++) begin
                if (SEQ[i] == obs_b0) begin
                    known_r <= 1'b1;
                    idx_r <= 4'(i);
                end
            end
        end
    end
    always_comb begin
        exp_next = known_r ? SEQ[(idx_r == 4'h8) ? 4'h0 : idx_r + 4'h1] : SEQ[0];
    end

    // ========================================
    // Properties
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    property p_cmd_answer;
        hdr_valid && hdr_id == 6'h25 |=> rsp_valid && rsp_len2;
    endproperty
    property p_safe_one_byte;
        rsp_valid && hdr_id == 6'h27 |-> !rsp_len2 && $past(hdr_valid);
    endproperty
    property p_set_field;
        rsp_valid && rsp_len2 |-> rsp_b1[7:6] == 2'h0 && rsp_b1[3:0] == 4'h0 && rsp_b1[5:4] != 2'h3;
    endproperty
    property p_code_range;
        rsp_valid && rsp_len2 |-> rsp_b0 <= 8'ha9 || rsp_b0 == 8'hff;
    endproperty
    property p_seq_next;
        rsp_valid && !rsp_len2 |-> rsp_b0 == exp_next;
    endproperty
    property p_seq_first;
        rsp_valid && !rsp_len2 && !known_r |-> rsp_b0 == 8'h3f;
    endproperty
    property p_seq_wrap;
        rsp_valid && !rsp_len2 && known_r && idx_r == 4'h8 |-> rsp_b0 == 8'h3f;
    endproperty
    property p_obs_follows;
        rsp_valid |-> ##2 obs_valid && obs_ok && obs_b0 == $past(rsp_b0, 2);
    endproperty
    property p_own_ids;
        rsp_valid |-> hdr_id == 6'h25 || hdr_id == 6'h27;
    endproperty
    property p_hdr_gap;
        hdr_valid |=> !hdr_valid [*3];
    endproperty

    a_cmd_answer: assert property (p_cmd_answer) else $error("command header not answered with two bytes");
    a_safe_one_byte: assert property (p_safe_one_byte) else $error("safety answer not one byte");
    a_set_field: assert property (p_set_field) else $error("bad code set byte");
    a_code_range: assert property (p_code_range) else $error("undefined function code sent");
    a_seq_next: assert property (p_seq_next) else $error("safety value out of order");
    a_seq_first: assert property (p_seq_first) else $error("unknown position not restarted");
    a_seq_wrap: assert property (p_seq_wrap) else $error("sequence did not wrap");
    a_obs_follows: assert property (p_obs_follows) else $error("answer not observed");
    a_own_ids: assert property (p_own_ids) else $error("answer to foreign frame");
    a_hdr_gap: assert property (p_hdr_gap) else $error("headers too close");

    c_wrap: cover property (rsp_valid && !rsp_len2 && known_r && idx_r == 4'h8);
    c_refused: cover property (hdr_valid && hdr_id == 6'h27 ##1 !rsp_valid);
    c_cmd: cover property (rsp_valid && rsp_len2 && rsp_b0 != 8'hff);
endmodule : hcs_link_chk

/* dv/handset_command_and_safety_sequence_tb.sv */
module handset_command_and_safety_sequence_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic key;
        logic [7:0] b37;
        logic [7:0] b39;
        logic [1:0] set;
        logic mot;
        logic known;
        logic [7:0] nxt;
    } hcs_note_t;
    localparam logic [7:0] SEQ [9] = '{8'h3f, 8'hdf, 8'hcf, 8'hd7, 8'hc3, 8'hdd, 8'hcc, 8'h55, 8'h80};
    localparam int N_ROUNDS = 80;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic key_pressed = 1'b0;
    logic [7:0] cmd_code = 8'h00;
    logic [1:0] cmd_set = 2'h0;
    logic active, motor_en, cmd_valid, seq_known, cmd_sent, safety_sent, k;
    logic [7:0] m_code, next_seq;
    logic [1:0] m_set;
    hcs_pkg::hcs_class_t m_class, h_class;
    int errors = 0;
    int n_compared = 0;
    hcs_note_t notes[$];
    hcs_note_t cur;
    logic [8:0] got37 = 9'h1ff;
    logic [8:0] got39 = 9'h1ff;
    logic known_m = 1'b0;
    int idx_m = 0;
    int run_m = 0;
    int n_cs = 0, n_ss = 0, n_cv = 0;

    hcs_link_if lnk();
    hcs_master #(.TWO_HS(1'b0), .GAP_CYC(4), .RESP_WAIT(2)) u_hcs_master (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .lnk(lnk), .active_o(active), .motor_en_o(motor_en), .cmd_valid_o(cmd_valid), .cmd_code_o(m_code),
        .cmd_set_o(m_set), .cmd_class_o(m_class));
    hcs_handset #(.SECOND(1'b0)) u_hcs_handset (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .lnk(lnk),
        .key_pressed_i(key_pressed), .cmd_code_i(cmd_code), .cmd_set_i(cmd_set), .seq_known_o(seq_known),
        .next_seq_o(next_seq), .cmd_class_o(h_class), .cmd_sent_o(cmd_sent), .safety_sent_o(safety_sent));
    hcs_link_chk u_hcs_link_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hdr_valid(lnk.hdr_valid),
        .hdr_id(lnk.hdr_id), .rsp_valid(lnk.rsp_valid), .rsp_len2(lnk.rsp_len2), .rsp_b0(lnk.rsp_b0),
        .rsp_b1(lnk.rsp_b1), .obs_valid(lnk.obs_valid), .obs_ok(lnk.obs_ok), .obs_id(lnk.obs_id),
        .obs_b0(lnk.obs_b0));

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic chk(string nm, logic [8:0] e, logic [8:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    function automatic hcs_pkg::hcs_class_t cls(logic [7:0] c);
        if (c == 8'hff) return hcs_pkg::CL_WAKE;
        if (c < 8'h80) return hcs_pkg::CL_BASIC;
        if (c inside {[8'h89:8'h8c], 8'ha6, 8'ha7}) return hcs_pkg::CL_MOTOR;
        if (c inside {[8'h8d:8'h90], 8'ha8, 8'ha9}) return hcs_pkg::CL_INTENS;
        if (c inside {[8'h92:8'ha5]}) return hcs_pkg::CL_AUX;
        return hcs_pkg::CL_MASSAGE;
    endfunction : cls

    task print_verdict;
        if (errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    // ========================================
    // One schedule round: set the keypad, note what the wire must show
    task automatic play(logic key, logic [7:0] code, logic [1:0] set);
        hcs_note_t n;
        n.key = key;
        n.b37 = (key && (code <= 8'ha9 || code == 8'hff)) ? code : 8'hff;
        n.set = (set == 2'h3) ? 2'h0 : set;
        n.b39 = 8'h00;
        if (key) begin
            n.b39 = known_m ? SEQ[(idx_m + 1) % 9] : SEQ[0];
            idx_m = known_m ? (idx_m + 1) % 9 : 0;
            known_m = 1'b1;
            run_m = (run_m < 3) ? run_m + 1 : 3;
        end else begin
            run_m = 0;
        end
        // Motors need an active command plus three good answers in a row
        n.mot = (n.b37 != 8'hff) && run_m >= 3;
        n.known = known_m;
        n.nxt = known_m ? SEQ[(idx_m + 1) % 9] : SEQ[0];
        key_pressed = key;
        cmd_code = code;
        cmd_set = set;
        notes.push_back(n);
    endtask : play

    // Inputs move only after the id 0 frame, well before the next header
    task next_round;
        do @(negedge clk_i); while (!(lnk.obs_valid && lnk.obs_id == 6'h00));
        @(posedge clk_i);
        #2;
    endtask : next_round

    always @(negedge clk_i) begin
        n_cs += cmd_sent;
        n_ss += safety_sent;
        n_cv += cmd_valid;
        if (lnk.obs_valid && lnk.obs_id == 6'h25) got37 = lnk.obs_ok ? {1'b1, lnk.obs_b0} : 9'h000;
        if (lnk.obs_valid && lnk.obs_id == 6'h27) got39 = lnk.obs_ok ? {1'b1, lnk.obs_b0} : 9'h000;
        if (lnk.obs_valid && lnk.obs_id == 6'h00 && notes.size() > 0) begin
            cur = notes.pop_front();
            chk("command byte", {1'b1, cur.b37}, got37);
            chk("safety byte", cur.key ? {1'b1, cur.b39} : 9'h000, got39);
            chk("master code", {1'b0, cur.b37}, {1'b0, m_code});
            if (cur.key) chk("code set", {7'h00, cur.set}, {7'h00, m_set});
            chk("wake class", {8'h00, cur.b37 == 8'hff}, {8'h00, m_class === hcs_pkg::CL_WAKE});
            chk("motor enable", {8'h00, cur.mot}, {8'h00, motor_en});
            chk("active", {8'h00, cur.b37 != 8'hff}, {8'h00, active});
            chk("next value", {cur.known, cur.nxt}, {seq_known, next_seq});
            chk("cmd sent", 9'h001, 9'(n_cs));
            chk("safety sent", {8'h00, cur.key}, 9'(n_ss));
            chk("cmd valid", 9'h001, 9'(n_cv));
            chk("handset class", {6'h00, cls(cur.b37)}, {6'h00, h_class});
            chk("master class", {6'h00, cls(cur.b37)}, {6'h00, m_class});
            got37 = 9'h1ff;
            got39 = 9'h1ff;
            n_cs = 0;
            n_ss = 0;
            n_cv = 0;
        end
    end

    initial begin
        void'($urandom(94));
        play(1'b0, 8'h00, 2'h0);
        repeat (4) @(posedge clk_i);
        #2 sys_rst_i = 1'b0;
        for (int i = 1; i < N_ROUNDS; i++) begin
            next_round();
            if (i <= 42) begin
                play(1'b1, 8'(127 + i), 2'($urandom % 4));
            end else if (i < N_ROUNDS - 2) begin
                k = ($urandom % 4) != 0;
                play(k, k ? 8'($urandom % 170) : 8'($urandom), 2'($urandom % 4));
            end else begin
                play(1'b1, (i == N_ROUNDS - 2) ? 8'hff : 8'hc8, 2'h1);
            end
        end
        next_round();
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        print_verdict();
    end
endmodule : handset_command_and_safety_sequence_tb
